/* File: logic/ndc_counter.v */
// Noise duration counter: prescale and main down counters with their control bus registers.
`include "ndc_regs.vh"

// Notes on behaviour
// - Main counter decrements per 80 ns tick when noise present and prescale is zero.
// - Prescale counter counts down every 80 ns tick while noise is present.
// - Prescale at zero reloads from its start value and decrements main counter.
// - Both zero in noise, active or unknown state reloads both start values.
// - In halt, idle, master, quiet or no-signal states both counters stay loaded.
// - Writing either start-value register reloads both counters.
// - Entering noise, active or unknown keeps counting with no reload.
// - Both counters at zero on a tick in noise, active or unknown state sets the noise-limit flag.
// - Main start value is seven bits; bit seven reads zero, writes ignored.
// - Prescale start value is a full eight-bit register.
// - Snapshot read returns the main counter value at that read.
// - Snapshot write changes nothing and raises the write-reject flag.
// - Snapshot holds count in bits zero to six, change indicator in bit seven.
// - Receive summary A is any condition bit set with its mask bit set.
// - Noise-limit mask bit five of mask register A clears at reset.
module ndc_counter (
  input wire core_clk, // 100 MHz clock
  input wire arst_n, // asynchronous reset, active low
  input wire [`NDC_ADDR_W-1:0] cb_addr, // control bus register address
  input wire cb_wr, // control bus write strobe, one cycle
  input wire cb_rd, // control bus read strobe, one cycle
  input wire [7:0] cb_wdata, // control bus write data
  output reg [7:0] cb_rdata, // read data, valid the cycle after cb_rd
  input wire [2:0] line_state, // current line state code from the detector
  input wire noise_event, // noise event present, sampled on each tick
  input wire noise_limit_clr, // clears the noise-limit flag, one cycle
  input wire [7:0] receive_cond_reg_a_in, // other condition A bits, bit five unused
  output reg noise_limit_flag, // sticky noise-limit condition
  output wire receive_summary_a_flag, // masked summary of condition register A
  output reg write_reject_flag // one-cycle pulse on a rejected write
);

  reg [`NDC_TICK_CNT_W-1:0] tick_cnt_r;
  reg [`NDC_COUNT_W-1:0] count_start_r;
  reg [`NDC_PRESCALE_W-1:0] prescale_start_r;
  reg [7:0] mask_a_r;
  reg [`NDC_COUNT_W-1:0] count_r;
  reg [`NDC_PRESCALE_W-1:0] prescale_r;
  reg [2:0] last_state_r;
  reg change_seen_r;
  wire tick;
  wire hold_state;
  wire both_zero;
  wire wr_count_start;
  wire wr_prescale_start;
  wire [`NDC_COUNT_W-1:0] new_count_start;
  wire [`NDC_PRESCALE_W-1:0] new_prescale_start;
  wire [7:0] cond_a;
  wire start_write;
  wire flag_set;
  wire snap_rd;
  wire snap_wr;
  reg [`NDC_COUNT_W-1:0] count_nxt;
  reg [`NDC_PRESCALE_W-1:0] prescale_nxt;
  reg [7:0] rdata_nxt;

  assign tick = (tick_cnt_r == `NDC_TICK_LAST);

  // hold-state decode of the detector's line state
  assign hold_state = (line_state == `NDC_LS_HALT) || (line_state == `NDC_LS_IDLE) ||
                      (line_state == `NDC_LS_MASTER) || (line_state == `NDC_LS_QUIET) ||
                      (line_state == `NDC_LS_NO_SIGNAL);
  assign both_zero = (count_r == {`NDC_COUNT_W{1'b0}}) && (prescale_r == 8'h00);
  assign wr_count_start = cb_wr && (cb_addr == `NDC_OFS_COUNT_START);
  assign wr_prescale_start = cb_wr && (cb_addr == `NDC_OFS_PRESCALE_START);
  assign start_write = wr_count_start || wr_prescale_start;
  assign snap_rd = cb_rd && (cb_addr == `NDC_OFS_COUNT_SNAPSHOT);
  assign snap_wr = cb_wr && (cb_addr == `NDC_OFS_COUNT_SNAPSHOT);
  // A hold state keeps the counters loaded, so a zero count there is not a limit.
  // A start-value write in the same tick does not stop a both-zero count raising the flag.
  assign flag_set = tick && !hold_state && both_zero;

  // The reload on a write uses the value being written, so no stale start value is loaded.
  assign new_count_start = wr_count_start ? cb_wdata[`NDC_COUNT_W-1:0] : count_start_r;
  assign new_prescale_start = wr_prescale_start ? cb_wdata : prescale_start_r;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= {`NDC_TICK_CNT_W{1'b0}};
    end else if (tick) begin
      tick_cnt_r <= {`NDC_TICK_CNT_W{1'b0}};
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_start_r <= `NDC_RST_COUNT_START;
      prescale_start_r <= `NDC_RST_PRESCALE_START;
      mask_a_r <= `NDC_RST_MASK_A;
    end else begin
      if (wr_count_start) begin
        count_start_r <= cb_wdata[`NDC_COUNT_W-1:0];
      end
      if (wr_prescale_start) begin
        prescale_start_r <= cb_wdata;
      end
      if (cb_wr && (cb_addr == `NDC_OFS_MASK_A)) begin
        mask_a_r <= cb_wdata;
      end
    end
  end

  // Priority per clock: start-value write, hold state, both-zero reload, then counting.
  always @* begin
    count_nxt = count_r;
    prescale_nxt = prescale_r;
    if (start_write) begin
      count_nxt = new_count_start;
      prescale_nxt = new_prescale_start;
    end else if (tick) begin
      if (hold_state) begin
        count_nxt = count_start_r;
        prescale_nxt = prescale_start_r;
      end else if (both_zero) begin
        count_nxt = count_start_r;
        prescale_nxt = prescale_start_r;
      end else if (noise_event) begin
        // no reload on entering a counting state
        if (prescale_r == 8'h00) begin
          prescale_nxt = prescale_start_r;
          count_nxt = count_r - 1'b1;
        end else begin
          prescale_nxt = prescale_r - 1'b1;
        end
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= `NDC_RST_COUNT_START;
      prescale_r <= `NDC_RST_PRESCALE_START;
    end else begin
      count_r <= count_nxt;
      prescale_r <= prescale_nxt;
    end
  end

  // A reset value of zero in both counters raises the flag on the first counting tick.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      noise_limit_flag <= 1'b0;
    end else if (flag_set) begin
      noise_limit_flag <= 1'b1;
    end else if (noise_limit_clr) begin
      noise_limit_flag <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_state_r <= `NDC_LS_UNKNOWN;
      change_seen_r <= 1'b0;
    end else begin
      last_state_r <= line_state;
      // change indicator, set wins over read clear
      if (line_state != last_state_r) begin
        change_seen_r <= 1'b1;
      end else if (snap_rd) begin
        change_seen_r <= 1'b0;
      end
    end
  end

  // Read data is selected here and captured only on a read, so it stands until the next read.
  always @* begin
    case (cb_addr)
      `NDC_OFS_MASK_A: begin
        rdata_nxt = mask_a_r;
      end
      `NDC_OFS_COUNT_START: begin
        rdata_nxt = {1'b0, count_start_r};
      end
      `NDC_OFS_PRESCALE_START: begin
        rdata_nxt = prescale_start_r;
      end
      `NDC_OFS_COUNT_SNAPSHOT: begin
        rdata_nxt = {change_seen_r, count_r};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cb_rdata <= 8'h00;
      write_reject_flag <= 1'b0;
    end else begin
      write_reject_flag <= snap_wr;
      if (cb_rd) begin
        cb_rdata <= rdata_nxt;
      end
    end
  end

  assign cond_a = {receive_cond_reg_a_in[7:6], noise_limit_flag, receive_cond_reg_a_in[4:0]};

  assign receive_summary_a_flag = |(cond_a & mask_a_r);

endmodule

/* File: logic/ndc_regs.vh */
// Register offsets, field layout, line-state codes and timing counts of the noise counter.
`ifndef NDC_REGS_VH
`define NDC_REGS_VH

`define NDC_ADDR_W 5
`define NDC_OFS_MASK_A 5'h0B
`define NDC_OFS_COUNT_START 5'h0D
`define NDC_OFS_PRESCALE_START 5'h0E
`define NDC_OFS_COUNT_SNAPSHOT 5'h0F

`define NDC_COUNT_W 7
`define NDC_PRESCALE_W 8
`define NDC_NOISE_LIMIT_BIT 5
`define NDC_SNAP_CHANGE_BIT 7

`define NDC_RST_COUNT_START 7'h00
`define NDC_RST_PRESCALE_START 8'h00
`define NDC_RST_MASK_A 8'h00

`define NDC_LS_HALT 3'h0
`define NDC_LS_IDLE 3'h1
`define NDC_LS_MASTER 3'h2
`define NDC_LS_QUIET 3'h3
`define NDC_LS_NO_SIGNAL 3'h4
`define NDC_LS_NOISE 3'h5
`define NDC_LS_ACTIVE 3'h6
`define NDC_LS_UNKNOWN 3'h7

`define NDC_TICK_NS 80
`define NDC_CLK_NS 10
`define NDC_TICK_CYCLES (`NDC_TICK_NS / `NDC_CLK_NS)
`define NDC_TICK_CNT_W 3
// Last tick counter value, one less than the clock cycles in one tick.
`define NDC_TICK_LAST 3'h7

`endif

/* File: verif/ndc_line_model.sv */
// Line state detector model that feeds line state and noise events.
module ndc_line_model (
  input wire core_clk, // clock
  input wire [3:0] cmd, // wanted state and event
  output reg [2:0] line_state = 3'h0, // line state code
  output reg noise_event = 1'h0 // noise present
);
  timeunit 1ns;
  timeprecision 100ps;
  // detector outputs
  // The command is taken at the edge and applied just after it, so the bench's update cannot race it.
  always @(posedge core_clk) begin
    {line_state, noise_event} <= #1 cmd;
  end
endmodule

/* File: verif/ndc_counter_properties.sv */
// Port checker of the noise counter.
module ndc_counter_props (
  input wire core_clk, // clock
  input wire arst_n, // reset, active low
  input wire [4:0] cb_addr, // register address
  input wire cb_wr, // write strobe
  input wire cb_rd, // read strobe
  input wire [7:0] cb_wdata, // write data
  input wire [7:0] cb_rdata, // read data
  input wire [2:0] line_state, // line state code
  input wire noise_event, // noise present
  input wire noise_limit_clr, // flag clear pulse
  input wire [7:0] receive_cond_reg_a_in, // other condition bits
  input wire noise_limit_flag, // noise-limit flag
  input wire receive_summary_a_flag, // masked summary
  input wire write_reject_flag // reject pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [7:0] m_r;
  wire snap_wr = cb_wr && cb_addr == 5'h0F;
  wire [7:0] cond_a = {receive_cond_reg_a_in[7:6], noise_limit_flag, receive_cond_reg_a_in[4:0]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // The mask is mirrored here because the summary cannot be judged without it.
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n) m_r <= 8'h00;
    else if (cb_wr && cb_addr == 5'h0B) m_r <= cb_wdata;
  a_reject_on_snap: assert property (snap_wr |=> write_reject_flag)
    else $error("reject missing");
  a_reject_cause: assert property (write_reject_flag |-> $past(snap_wr))
    else $error("reject uncaused");
  a_summary_masked: assert property (receive_summary_a_flag == |(m_r & cond_a))
    else $error("summary wrong");
  a_start_bit7: assert property (cb_rd && cb_addr == 5'h0D |=> !cb_rdata[7])
    else $error("bit seven set");
  a_prescale_back: assert property (cb_wr && cb_addr == 5'h0E ##1 !cb_wr ##1 cb_rd &&
    cb_addr == 5'h0E |=> cb_rdata == $past(cb_wdata, 3)) else $error("prescale lost");
  a_flag_sticky: assert property (noise_limit_flag && !noise_limit_clr |=> noise_limit_flag)
    else $error("flag dropped");
  a_flag_counting: assert property ($rose(noise_limit_flag) |-> $past(line_state) > 3'h4)
    else $error("flag in hold");
  a_change_seen: assert property ($changed(line_state) ##1 cb_rd && cb_addr == 5'h0F |=>
    cb_rdata[7]) else $error("change unseen");
endmodule
bind ndc_counter ndc_counter_props props_u (.core_clk, .arst_n, .cb_addr, .cb_wr, .cb_rd,
  .cb_wdata, .cb_rdata, .line_state, .noise_event, .noise_limit_clr, .receive_cond_reg_a_in,
  .noise_limit_flag, .receive_summary_a_flag, .write_reject_flag);

/* File: verif/ndc_counter_tb.sv */
// Self-checking bench of the noise counter with a reference model.
module ndc_counter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  reg core_clk = 1'h0, arst_n = 1'h0, cb_wr = 1'h0, cb_rd = 1'h0, noise_limit_clr = 1'h0, flag;
  reg ch, ch_at;
  reg [4:0] cb_addr = 5'h00, a;
  reg [7:0] cb_wdata = 8'h00, cond_a = 8'h00, ps, p, mk;
  reg [6:0] cs, c, c_at;
  reg [3:0] cmd = 4'h0;
  reg [2:0] tk, ls_q;
  reg [31:0] seed = 32'h0000004E;
  integer error_cnt = 0, comparisons = 0, cyc = 0, i;
  wire [7:0] cb_rdata;
  wire [2:0] line_state;
  wire noise_event, noise_limit_flag, summary, write_reject_flag;
  wire wr_ld = cb_wr && (cb_addr == 5'h0D || cb_addr == 5'h0E);
  wire snap_rd = cb_rd && cb_addr == 5'h0F;
  wire tick = tk == 3'h7;
  ndc_counter dut_u (.core_clk, .arst_n, .cb_addr, .cb_wr, .cb_rd, .cb_wdata, .cb_rdata,
    .line_state, .noise_event, .noise_limit_clr, .receive_cond_reg_a_in(cond_a),
    .noise_limit_flag, .receive_summary_a_flag(summary), .write_reject_flag);
  ndc_line_model line_u (.core_clk, .cmd, .line_state, .noise_event);
  initial forever #5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Summary expected from the mask, the other condition bits and the modelled flag.
  function automatic logic [7:0] sum_exp(input logic [7:0] m, input logic [7:0] ca,
      input logic f);
    return {7'h00, |(m & {ca[7:6], f, ca[4:0]})};
  endfunction
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n) begin
      {tk, cs, ps, c, p, flag, mk, ch} <= '0;
      ls_q <= 3'h7;
    end else begin
      tk <= tk + 3'h1;
      ls_q <= line_state;
      if (snap_rd) {ch_at, c_at} <= {ch, c};
      ch <= line_state != ls_q || ch && !snap_rd;
      if (cb_wr && cb_addr == 5'h0B) mk <= cb_wdata;
      flag <= flag && !noise_limit_clr || tick && line_state > 3'h4 && {c, p} == 15'h0;
      if (wr_ld) begin
        cs <= cb_addr[0] ? cb_wdata[6:0] : cs;
        ps <= cb_addr[0] ? ps : cb_wdata;
        c <= cb_addr[0] ? cb_wdata[6:0] : cs;
        p <= cb_addr[0] ? ps : cb_wdata;
      end else if (tick && (line_state < 3'h5 || {c, p} == 15'h0)) begin
        c <= cs;
        p <= ps;
      end else if (tick && noise_event) begin
        c <= c - {6'h00, p == 8'h00};
        p <= p == 8'h00 ? ps : p - 8'h01;
      end
    end
  task chk(input [7:0] seen, input [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input w, input [4:0] a, input [7:0] d);
    @(posedge core_clk);
    #1 {cb_wr, cb_rd, cb_addr, cb_wdata} = {w, !w, a, d};
    @(posedge core_clk);
    #1 {cb_wr, cb_rd} = 2'h0;
  endtask
  task stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) if (++cyc > 20000) begin
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'h1;
    for (i = 11; i < 15; i++) begin
      bus(1'h0, i[4:0], 8'h00);
      chk(cb_rdata, 8'h00);
    end
    bus(1'h1, 5'h0D, 8'hFF);
    bus(1'h0, 5'h0D, 8'h00);
    chk(cb_rdata, 8'h7F);
    bus(1'h1, 5'h0E, 8'hA5);
    bus(1'h0, 5'h0E, 8'h00);
    chk(cb_rdata, 8'hA5);
    bus(1'h1, 5'h0F, 8'h3C);
    chk({7'h00, write_reject_flag}, 8'h01);
    for (i = 0; i < 300; i++) begin
      seed = xs(seed);
      {cond_a, cmd, noise_limit_clr} = {seed[15:8], seed[3:0], seed[17:16] == 2'h3};
      @(posedge core_clk);
      #1 noise_limit_clr = 1'h0;
      if (seed[20:18] < 3'h4) begin
        a = seed[19] ? (seed[18] ? 5'h0F : 5'h0B) : 5'h0D + seed[18];
        bus(1'h1, a, seed[31:24] & (a == 5'h0B ? 8'hFF : 8'h03));
        chk({7'h00, write_reject_flag}, {7'h00, a == 5'h0F});
      end
      repeat (seed[25:24]) @(posedge core_clk);
      bus(1'h0, 5'h0F, 8'h00);
      chk(cb_rdata, {ch_at, c_at});
      chk({7'h00, noise_limit_flag}, {7'h00, flag});
      chk({7'h00, summary}, sum_exp(mk, cond_a, flag));
    end
    // A reset in mid-run must clear the mask written just before it.
    bus(1'h1, 5'h0B, 8'hFF);
    arst_n = 1'h0;
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'h1;
    bus(1'h0, 5'h0B, 8'h00);
    chk(cb_rdata, 8'h00);
    chk({7'h00, noise_limit_flag}, 8'h00);
    chk({7'h00, summary}, 8'h00);
    bus(1'h0, 5'h0F, 8'h00);
    chk(cb_rdata, {ch_at, c_at});
    stop_test;
  end
endmodule
